/* core/ccw_defs.svh */
// Register map, field positions, reset values for the comparator control block
`ifndef CCW_DEFS_SVH
`define CCW_DEFS_SVH
// Register indexes; byte address is four times the index
`define CCW_IDX_STATUS 6'h03
`define CCW_IDX_CTRL 6'h07
`define CCW_IDX_PINDIR 6'h08
`define CCW_IDX_TOPT 6'h09
// Control register fields
`define CCW_B_RESULT 7
`define CCW_B_OUTDIS 6
`define CCW_B_INVSEL 5
`define CCW_B_TCFC 4
`define CCW_B_POWER 3
`define CCW_B_NEGSEL 2
`define CCW_B_POSSEL 1
`define CCW_B_WAKEN 0
// Status register field
`define CCW_B_WFLAG 6
// Timer option field
`define CCW_B_TSS 0
// Reset values
`define CCW_RST_CTRL 8'hff
`define CCW_RST_PINDIR 4'hf
`define CCW_RST_TSS 1'b1
`endif

/* core/ccw_pkg.sv */
// Types shared by the comparator control block
package ccw_pkg;
   // Timer clock source choice
   typedef enum logic [1:0]
   {
      CCW_TSRC_INSTR = 2'b00,
      CCW_TSRC_COMP = 2'b01,
      CCW_TSRC_EXT = 2'b10
   } ccw_tsrc_t;
   // Pin group toward the port pads
   typedef struct packed
   {
      logic [3:0] o;
      logic [3:0] oe;
      logic [1:0] analog;
   } ccw_pins_t;
   // Whole state of the control block
   typedef struct packed
   {
      logic [6:0] ctl;
      logic tss;
      logic [3:0] pin_dir;
      logic result;
      logic ref_state;
      logic ref_valid;
      logic wake_flag;
      logic wr_pend;
      logic [5:0] wr_idx;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      ccw_tsrc_t tsrc;
      logic tsrc_level;
      logic pwr;
      logic neg_sel;
      logic pos_sel;
      ccw_pins_t pins;
      logic wake_req;
   } ccw_state_t;
endpackage

/* core/ccw_sync.sv */
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
module ccw_sync
#(
   parameter int W = 2
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // Stage 0 feeds stage 1 only
   logic [1:0][W-1:0] st_r;
   logic [1:0][W-1:0] st_nxt;

   // Next state: shift one stage
   always_comb
   begin
      st_nxt = st_r;
      st_nxt[0] = d;
      st_nxt[1] = st_r[0];
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r[1];
endmodule

/* core/ccw_top.sv */
// Comparator control, pin steering, timer source and wake logic with AHB-Lite registers
`timescale 1ns/1ps
`include "ccw_defs.svh"
module ccw_top
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic comp_raw,
   input wire logic timer_pin_in,
   input wire logic [3:0] port_data,
   input wire logic sleep_active,
   input wire logic dev_reset,
   input wire logic reset_by_comp_wake,
   output logic comparator_power,
   output logic negative_ref_select,
   output logic positive_ref_select,
   output ccw_pkg::ccw_tsrc_t timer_src_sel,
   output logic timer_src_level,
   output ccw_pkg::ccw_pins_t port_pins,
   output logic wake_request
);
   import ccw_pkg::*;

   // ==================================================
   // Timing at a glance
   // ==================================================
   // Bus: zero wait states, always OKAY
   // Read data stands for one cycle in the data phase, zero otherwise
   // A read right behind a write to the same word sees the new value
   // A control write lands at its data-phase edge
   // Steering, pad and timer outputs follow one edge after that
   // Comparator decision passes two sync flops and the result flop
   // So the result bit trails the analog decision by three edges
   // The analog side needs its own settling time on top of that
   // The wake reference is the very value a control read returns
   // Any control write drops the reference until control is read again
   // A non-power-on reset also drops it
   // In sleep a result that differs from the reference sets the flag
   // A flag set outranks a software clear in the same cycle
   // Only the comparator wake-up reset keeps the flag
   // With power off the result holds and steering bits are ignored
   // The comparator stays powered in sleep if software leaves it on

   // ==================================================
   // Declarations
   // ==================================================
   ccw_state_t s_r; // Registered state
   ccw_state_t s_nxt; // Next state
   logic [1:0] sync_q; // Synchronised comparator and timer pin
   logic comp_s; // Synchronised comparator decision
   logic tpin_s; // Synchronised timer pin level
   logic acc; // Address phase accepted
   logic rd_acc; // Read accepted
   logic [5:0] acc_idx; // Word index of accepted address
   logic on; // Comparator powered

   // ==================================================
   // Read data decode
   // ==================================================
   // Builds the read word of one register from a state copy
   function automatic logic [31:0] rd_word(input logic [5:0] idx, input ccw_state_t st);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (idx)
         `CCW_IDX_STATUS:
         begin
            w[`CCW_B_WFLAG] = st.wake_flag;
         end
         `CCW_IDX_CTRL:
         begin
            w[6:0] = st.ctl;
            w[`CCW_B_RESULT] = st.result;
         end
         `CCW_IDX_PINDIR:
         begin
            w[3:0] = st.pin_dir;
         end
         `CCW_IDX_TOPT:
         begin
            w[`CCW_B_TSS] = st.tss;
         end
         default:
         begin
            w = 32'h0000_0000;
         end
      endcase
      return w;
   endfunction

   // ==================================================
   // Input synchronisation
   // ==================================================
   // Both pad-side levels cross through two flops
   // Bit 0 is the comparator decision, bit 1 the timer pin
   ccw_sync #(.W(2)) u_sync
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({timer_pin_in, comp_raw}),
      .q(sync_q)
   );

   assign comp_s = sync_q[0];
   assign tpin_s = sync_q[1];

   // ==================================================
   // Bus decode
   // ==================================================
   // A transfer is taken on NONSEQ or SEQ with the bus ready
   // IDLE and BUSY are ignored; size is not checked, only whole words map
   assign acc = hsel && htrans[1] && hready;
   assign rd_acc = acc && !hwrite;
   assign acc_idx = haddr[7:2];
   assign on = s_r.ctl[`CCW_B_POWER];

   // ==================================================
   // Next-state logic
   // ==================================================
   // Next state of the whole block
   // Later assignments win, which orders the priorities below
   always_comb
   begin
      s_nxt = s_r;

      // Zero wait state slave, always OKAY
      s_nxt.hreadyout = 1'b1;
      s_nxt.hresp = 1'b0;

      // Result bit: invert when select is clear, hold while off
      // Holding keeps a powered-down comparator's noise out of the flag
      if (on)
      begin
         s_nxt.result = comp_s ^ ~s_r.ctl[`CCW_B_INVSEL];
      end

      // Data phase of a write
      // Index was captured at the address phase edge
      if (s_r.wr_pend)
      begin
         case (s_r.wr_idx)
            `CCW_IDX_CTRL:
            begin
               // Bit 7 is read-only; any write drops the reference
               s_nxt.ctl = hwdata[6:0];
               s_nxt.ref_valid = 1'b0;
            end
            `CCW_IDX_STATUS:
            begin
               // Writing zero clears the wake flag
               if (!hwdata[`CCW_B_WFLAG])
               begin
                  s_nxt.wake_flag = 1'b0;
               end
            end
            `CCW_IDX_PINDIR:
            begin
               s_nxt.pin_dir = hwdata[3:0];
            end
            `CCW_IDX_TOPT:
            begin
               s_nxt.tss = hwdata[`CCW_B_TSS];
            end
            default:
            begin
               // Unmapped writes are dropped
               s_nxt.pin_dir = s_r.pin_dir;
            end
         endcase
      end

      // Other device resets: control kept, flag by reset kind
      if (dev_reset)
      begin
         s_nxt.ref_valid = 1'b0;
         if (!reset_by_comp_wake)
         begin
            s_nxt.wake_flag = 1'b0;
         end
      end

      // Reading control latches the reference state
      if (rd_acc && (acc_idx == `CCW_IDX_CTRL))
      begin
         // Latch what this read returns, so a change in this cycle is not lost
         s_nxt.ref_state = s_nxt.result;
         s_nxt.ref_valid = 1'b1;
      end

      // Change during sleep sets the flag; set beats any clear
      // Needs wake enabled, a valid reference and the comparator on
      if (on && !s_r.ctl[`CCW_B_WAKEN] && s_r.ref_valid && sleep_active
          && (s_r.result != s_r.ref_state))
      begin
         s_nxt.wake_flag = 1'b1;
      end

      // Write address phase is held for the data phase
      s_nxt.wr_pend = acc && hwrite;
      s_nxt.wr_idx = acc_idx;

      // Read word taken after this cycle's write lands
      if (rd_acc)
      begin
         s_nxt.hrdata = rd_word(acc_idx, s_nxt);
      end
      else
      begin
         s_nxt.hrdata = 32'h0000_0000;
      end

      // Analog steering; comparator stays on in sleep
      s_nxt.pwr = on;
      s_nxt.neg_sel = on && s_r.ctl[`CCW_B_NEGSEL];
      s_nxt.pos_sel = on && s_r.ctl[`CCW_B_POSSEL];

      // Timer clock source
      // Select bit clear: instruction cycle whatever the comparator does
      // Comparator off: the timer pin, since the control bits are ignored
      // Timer-from-compare and output disable both set: the timer pin
      if (!s_r.tss)
      begin
         s_nxt.tsrc = CCW_TSRC_INSTR;
      end
      else if (!on || (s_r.ctl[`CCW_B_TCFC] && s_r.ctl[`CCW_B_OUTDIS]))
      begin
         s_nxt.tsrc = CCW_TSRC_EXT;
      end
      else
      begin
         s_nxt.tsrc = CCW_TSRC_COMP;
      end
      s_nxt.tsrc_level = (s_nxt.tsrc == CCW_TSRC_COMP) ? s_nxt.result : tpin_s;

      // First two pins: analog when feeding the comparator
      // Analog pins never drive, whatever the direction register holds
      s_nxt.pins.analog[0] = on && s_r.ctl[`CCW_B_POSSEL];
      s_nxt.pins.analog[1] = on && (s_r.ctl[`CCW_B_NEGSEL] || !s_r.ctl[`CCW_B_POSSEL]);
      s_nxt.pins.o = port_data;
      s_nxt.pins.oe = ~s_r.pin_dir;
      if (s_nxt.pins.analog[0])
      begin
         s_nxt.pins.oe[0] = 1'b0;
      end
      if (s_nxt.pins.analog[1])
      begin
         s_nxt.pins.oe[1] = 1'b0;
      end

      // Third pin: comparator drive first, then timer input
      // Comparator output enable outranks the timer select for this pin's direction
      if (on && !s_r.ctl[`CCW_B_OUTDIS])
      begin
         s_nxt.pins.o[2] = s_nxt.result;
         s_nxt.pins.oe[2] = 1'b1;
      end
      else if (s_r.tss)
      begin
         s_nxt.pins.oe[2] = 1'b0;
      end

      // Fourth pin is input only
      s_nxt.pins.oe[3] = 1'b0;

      s_nxt.wake_req = s_nxt.wake_flag;
   end

   // ==================================================
   // State register
   // ==================================================
   // Power-on loads ones; power output stays low until release
   // Control bits 6:0 read back as ones, so every comparator pin starts analog
   // Pads and selects stay parked at zero while reset is held
   // Other device resets never come through here; they arrive on dev_reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         // Clear everything, then load the power-on values
         s_r <= '0;
         s_r.ctl <= 7'h7f;
         s_r.result <= 1'b1;
         s_r.pin_dir <= `CCW_RST_PINDIR;
         s_r.tss <= `CCW_RST_TSS;
         s_r.hreadyout <= 1'b1;
         s_r.tsrc <= CCW_TSRC_INSTR;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ==================================================
   // Outputs
   // ==================================================
   // Every output is a field of the state register
   // No logic sits after the flops, so pads and the analog side
   // see clean levels with no decode glitches
   assign hrdata = s_r.hrdata;
   assign hreadyout = s_r.hreadyout;
   assign hresp = s_r.hresp;
   assign comparator_power = s_r.pwr;
   assign negative_ref_select = s_r.neg_sel;
   assign positive_ref_select = s_r.pos_sel;
   assign timer_src_sel = s_r.tsrc;
   assign timer_src_level = s_r.tsrc_level;
   assign port_pins = s_r.pins;
   assign wake_request = s_r.wake_req;
endmodule

/* tb/ccw_checker.sv */
// Concurrent checks on the comparator control top ports
`timescale 1ns/1ps
`include "ccw_defs.svh"
module ccw_checker
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic sleep_active,
   input wire logic dev_reset,
   input wire logic reset_by_comp_wake,
   input wire logic comparator_power,
   input wire logic negative_ref_select,
   input wire logic positive_ref_select,
   input wire ccw_pkg::ccw_pins_t port_pins,
   input wire logic wake_request
);
   import ccw_pkg::*;
   logic tk;
   logic wc;
   // =====
   // Transfer decode
   assign tk = hsel & htrans[1] & hready;
   assign wc = tk & hwrite & (haddr[7:0] == {`CCW_IDX_CTRL, 2'b00});
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus answer not okay");
   a_rdata_idle: assert property (!$past(tk && !hwrite) |-> hrdata == 32'h0000_0000)
      else $error("read data outside data phase");
   a_power_follow: assert property (wc |-> ##3 comparator_power == $past(hwdata[3], 2))
      else $error("power does not follow write");
   a_sel_follow: assert property (wc |-> ##3 (!$past(hwdata[3], 2) ||
      (negative_ref_select == $past(hwdata[2], 2) && positive_ref_select == $past(hwdata[1], 2))))
      else $error("selects do not follow write");
   a_off_analog: assert property (!comparator_power |-> port_pins.analog == 2'b00)
      else $error("analog pins while off");
   a_pin3_input: assert property (port_pins.oe[3] == 1'b0)
      else $error("pin three driven");
   a_wake_sleep: assert property ($rose(wake_request) |-> $past(sleep_active) || $past(sleep_active, 2))
      else $error("wake outside sleep");
   a_rst_clear: assert property (dev_reset && !reset_by_comp_wake && !sleep_active |-> ##2 !wake_request)
      else $error("flag kept over reset");
   a_wake_kept: assert property (dev_reset && reset_by_comp_wake && wake_request |=> wake_request)
      else $error("flag lost on wake reset");
   c_ctrl_write: cover property (wc);
   c_wake: cover property ($rose(wake_request));
   c_wake_rst: cover property (dev_reset && reset_by_comp_wake);
endmodule
bind ccw_top ccw_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .hrdata, .hreadyout, .hresp, .sleep_active, .dev_reset, .reset_by_comp_wake, .comparator_power,
   .negative_ref_select, .positive_ref_select, .port_pins, .wake_request);

/* tb/ccw_cmp_model.sv */
// Behavioural analog comparator with input steering
`timescale 1ns/1ps
module ccw_cmp_model
(
   input wire logic hclk,
   input wire logic comparator_power,
   input wire logic negative_ref_select,
   input wire logic positive_ref_select,
   input wire logic [7:0] vin_pos,
   input wire logic [7:0] vin_neg,
   input wire logic [7:0] vref,
   output logic comp_raw
);
   logic [7:0] plus;
   logic [7:0] minus;
   // Input steering ahead of the decision
   assign plus = positive_ref_select ? vin_pos : vin_neg;
   assign minus = negative_ref_select ? vin_neg : vref;
   // Decision; an unpowered comparator gives a meaningless toggling level
   initial comp_raw = 1'b0;
   always @(posedge hclk)
      comp_raw <= comparator_power ? (plus > minus) : !comp_raw;
endmodule

/* tb/testbench.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "ccw_defs.svh"
module testbench;
   import ccw_pkg::*;
   localparam logic [7:0] AS = {`CCW_IDX_STATUS, 2'b00};
   localparam logic [7:0] AC = {`CCW_IDX_CTRL, 2'b00};
   localparam logic [7:0] AP = {`CCW_IDX_PINDIR, 2'b00};
   localparam logic [7:0] AT = {`CCW_IDX_TOPT, 2'b00};
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, timer_pin_in, sleep_active, dev_reset;
   logic reset_by_comp_wake, comp_raw, comparator_power, negative_ref_select, positive_ref_select;
   logic timer_src_level, wake_request;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] port_data;
   logic [7:0] vin_neg;
   ccw_tsrc_t timer_src_sel;
   ccw_pins_t port_pins;
   int fail_count = 0;
   int num_checks = 0;
   int i;
   ccw_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .comp_raw, .timer_pin_in, .port_data, .sleep_active, .dev_reset,
      .reset_by_comp_wake, .comparator_power, .negative_ref_select, .positive_ref_select,
      .timer_src_sel, .timer_src_level, .port_pins, .wake_request);
   ccw_cmp_model u_cmp (.hclk, .comparator_power, .negative_ref_select, .positive_ref_select,
      .vin_pos(8'h80), .vin_neg, .vref(8'h60), .comp_raw);
   // =====
   // Clock
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = !hclk;
   end
   // =====
   // Verdict and run end
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("Error at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // =====
   // Bus cycles: wait for ready under a bound
   task automatic hw;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
         if (n > 9)
         begin
            fail_count++;
            final_report;
         end
      end
      while (hreadyout !== 1'b1);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      hw;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      hw;
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, {24'h00_0000, d}, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, r);
      chk(r, {24'h00_0000, e});
   endtask
   task automatic tsrc(input logic [7:0] c, input logic t, input ccw_tsrc_t e);
      wr(AC, c);
      wr(AT, {7'h00, t});
      cyc(2);
      chk(timer_src_sel, e);
   endtask
   // Arm the reference, sleep, flip the comparator and wait for the flag
   task automatic wake_up;
      int n;
      wr(AC, 8'h2e);
      cyc(5);
      rd(AC, 8'hae);
      sleep_active <= 1'b1;
      vin_neg <= 8'hc0;
      n = 0;
      while (wake_request !== 1'b1 && n < 20)
      begin
         @(posedge hclk);
         n++;
      end
      chk(wake_request, 1'b1);
      chk(comparator_power, 1'b1);
      if (wake_request !== 1'b1)
         final_report;
      sleep_active <= 1'b0;
      vin_neg <= 8'h40;
   endtask
   // Arm only if rd_first is set, sleep and flip, then expect no flag
   task automatic no_wake(input logic [7:0] c, input logic rd_first);
      wr(AC, c);
      cyc(5);
      if (rd_first)
         rd(AC, 8'h80 | c);
      sleep_active <= 1'b1;
      vin_neg <= 8'hc0;
      cyc(10);
      chk(wake_request, 1'b0);
      sleep_active <= 1'b0;
      vin_neg <= 8'h40;
      cyc(6);
   endtask
   // =====
   // Main sequence
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = 3'b010;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      timer_pin_in = 1'b0;
      port_data = 4'h5;
      sleep_active = 1'b0;
      dev_reset = 1'b0;
      reset_by_comp_wake = 1'b0;
      vin_neg = 8'h40;
      cyc(5);
      hresetn <= 1'b1;
      // Let the comparator power up and settle before trusting the result
      cyc(6);
      rd(AC, 8'hff);
      rd(AP, 8'h0f);
      rd(AT, 8'h01);
      rd(8'h40, 8'h00);
      rd(AS, 8'h00);
      chk(port_pins.analog, 2'b11);
      chk(port_pins.oe, 4'h0);
      chk(port_pins.o, 4'h5);
      timer_pin_in <= 1'b1;
      cyc(5);
      chk(timer_src_level, 1'b1);
      wr(AC, 8'h0e);
      cyc(5);
      rd(AC, 8'h0e);
      chk(port_pins.oe[2], 1'b1);
      chk(port_pins.o[2], 1'b0);
      chk(timer_src_level, 1'b0);
      wr(AC, 8'h2e);
      cyc(5);
      rd(AC, 8'hae);
      chk(port_pins.o[2], 1'b1);
      vin_neg <= 8'hc0;
      cyc(6);
      rd(AC, 8'h2e);
      vin_neg <= 8'h40;
      for (i = 0; i < 4; i++)
      begin
         wr(AC, 8'h28 | 8'(i << 1));
         cyc(6);
         rd(AC, 8'h28 | 8'(i << 1) | {i[0], 7'h00});
         chk(port_pins.analog, {i[1] | !i[0], i[0]});
         chk({negative_ref_select, positive_ref_select}, i[1:0]);
      end
      tsrc(8'h78, 1'b1, CCW_TSRC_EXT);
      chk(port_pins.oe[2], 1'b0);
      tsrc(8'h68, 1'b1, CCW_TSRC_COMP);
      tsrc(8'h38, 1'b1, CCW_TSRC_COMP);
      tsrc(8'h78, 1'b0, CCW_TSRC_INSTR);
      wr(AC, 8'h2e);
      cyc(5);
      wr(AC, 8'h27);
      cyc(2);
      chk(comparator_power, 1'b0);
      rd(AC, 8'ha7);
      wr(AP, 8'h00);
      cyc(2);
      chk(port_pins.oe, 4'h7);
      wr(AT, 8'h01);
      cyc(2);
      chk(port_pins.oe, 4'h3);
      wr(AP, 8'h0f);
      wake_up;
      rd(AS, 8'h40);
      wr(AS, 8'h00);
      rd(AS, 8'h00);
      no_wake(8'h2e, 1'b0);
      no_wake(8'h2f, 1'b1);
      wake_up;
      reset_by_comp_wake <= 1'b1;
      dev_reset <= 1'b1;
      cyc(1);
      dev_reset <= 1'b0;
      cyc(2);
      chk(wake_request, 1'b1);
      reset_by_comp_wake <= 1'b0;
      dev_reset <= 1'b1;
      cyc(1);
      dev_reset <= 1'b0;
      cyc(2);
      chk(wake_request, 1'b0);
      final_report;
   end
endmodule
